// >>> logic/acc_ctrl.sv
`timescale 1ns/1ps
module acc_ctrl #(
   parameter int TICK_CYC = acc_pkg::TICK_CYC,
   parameter int CONV_CYC = acc_pkg::CONV_CYC
) (
   input  wire logic        ref_clk_i,
   input  wire logic        nrst_i,
   input  wire logic [7:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic [31:0]      rdata_o,
   output logic             oneshot_irq_o,
   output logic             periodic_irq_o,
   output logic             core_reset_o,
   output logic             core_powerdown_o,
   output logic [3:0]       mux_chan_o,
   output logic             busy_o
);
   typedef enum logic [1:0] {ACC_IDLE, ACC_SCAN, ACC_WAIT} acc_state_e;

   acc_state_e  state_r;
   logic [7:0]  ctrl_r;
   logic [31:0] delay_r;
   logic [15:0] smask_r;
   logic [15:0] pmask_r;
   logic [15:0] cur_mask_r;
   logic        cur_per_r;
   logic [3:0]  chan_r;
   logic        one_pend_r;
   logic        per_pend_r;
   logic [15:0] ptimer_r;
   logic        first_r;
   logic        act_q_r;
   logic        start_r;
   logic [31:0] rdata_r;
   logic        tick;

   acc_conv_if cv ();

   wire act      = ctrl_r[acc_pkg::B_ACTIVATE];
   wire per_run  = ctrl_r[acc_pkg::B_PERIODIC_RUN];
   wire hw_rst   = ctrl_r[acc_pkg::B_CORE_RESET];
   wire wr_ctrl  = wr_i && (addr_i == acc_pkg::OFF_CTRL);
   wire wr_delay = wr_i && (addr_i == acc_pkg::OFF_DELAY);
   wire wr_smask = wr_i && (addr_i == acc_pkg::OFF_SMASK);
   wire wr_pmask = wr_i && (addr_i == acc_pkg::OFF_PMASK);
   wire idle     = (state_r == ACC_IDLE);

   function automatic logic [4:0] next_ch(input logic [15:0] m, input logic [4:0] from);
      logic [4:0] r;
      r = 5'h10;
      for (int i = 15; i >= 0; i--) begin
         if (m[i] && (5'(i) >= from)) begin
            r = 5'(i);
         end
      end
      return r;
   endfunction

   wire [4:0] first_ch  = next_ch(cur_mask_r, 5'h00);
   wire [4:0] after_ch  = next_ch(cur_mask_r, {1'b0, chan_r} + 5'h01);
   wire       launch    = idle && act && !hw_rst && (one_pend_r || per_pend_r);
   wire       launch_os = launch && one_pend_r;
   wire       finish    = (state_r == ACC_WAIT)
                          && (cur_mask_r == 16'h0000 || (cv.done && after_ch[4]));
   wire       per_load  = first_r ? delay_r[15:0] != 16'h0000 : delay_r[31:16] != 16'h0000;
   wire [15:0] per_reload = first_r ? delay_r[15:0] : delay_r[31:16];
   wire       ptimer_exp = per_run && !per_pend_r && (ptimer_r == 16'h0000);

   acc_tick #(.TICK_CYC(TICK_CYC)) u_tick (
      .ref_clk_i (ref_clk_i),
      .nrst_i    (nrst_i),
      .clr_i     (!per_run),
      .tick_o    (tick)
   );

   acc_core_timer #(.CONV_CYC(CONV_CYC)) u_core (
      .ref_clk_i (ref_clk_i),
      .nrst_i    (nrst_i),
      .cv        (cv.core)
   );

   assign cv.start = start_r;
   assign cv.chan  = chan_r;
   assign cv.hold  = hw_rst;

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctrl_r <= 8'h00;
      end else begin
         if (wr_ctrl) begin
            ctrl_r[4:0] <= {wdata_i[4:2], 1'b0, wdata_i[0]};
            ctrl_r[5]   <= 1'b0;
         end
         if (wr_ctrl && wdata_i[acc_pkg::B_ONESHOT_RUN]) begin
            ctrl_r[acc_pkg::B_ONESHOT_RUN] <= 1'b1;
         end else if (one_pend_r && launch_os) begin
            ctrl_r[acc_pkg::B_ONESHOT_RUN] <= 1'b0;
         end
         if (finish && !cur_per_r) begin
            ctrl_r[acc_pkg::B_ONE_DONE] <= 1'b1;
         end else if (launch_os) begin
            ctrl_r[acc_pkg::B_ONE_DONE] <= 1'b0;
         end else if (wr_ctrl && wdata_i[acc_pkg::B_ONE_DONE]) begin
            ctrl_r[acc_pkg::B_ONE_DONE] <= 1'b0;
         end
         if (finish && cur_per_r) begin
            ctrl_r[acc_pkg::B_PER_DONE] <= 1'b1;
         end else if (launch && !one_pend_r) begin
            ctrl_r[acc_pkg::B_PER_DONE] <= 1'b0;
         end else if (wr_ctrl && wdata_i[acc_pkg::B_PER_DONE]) begin
            ctrl_r[acc_pkg::B_PER_DONE] <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         delay_r <= 32'h0000_0000;
         smask_r <= 16'h0000;
         pmask_r <= 16'h0000;
      end else begin
         if (wr_delay) begin
            delay_r <= wdata_i;
         end
         if (wr_smask) begin
            smask_r <= wdata_i[15:0];
         end
         if (wr_pmask) begin
            pmask_r <= wdata_i[15:0];
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         one_pend_r <= 1'b0;
      end else if (wr_ctrl && wdata_i[acc_pkg::B_ONESHOT_RUN]) begin
         one_pend_r <= 1'b1;
      end else if (launch_os) begin
         one_pend_r <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         per_pend_r <= 1'b0;
         ptimer_r   <= 16'h0000;
         first_r    <= 1'b1;
      end else if (!per_run) begin
         per_pend_r <= 1'b0;
         ptimer_r   <= 16'h0000;
         first_r    <= 1'b1;
      end else begin
         if (first_r) begin
            ptimer_r <= delay_r[15:0];
            first_r  <= 1'b0;
            per_pend_r <= !per_load;
         end else if (ptimer_exp) begin
            per_pend_r <= 1'b1;
         end else if (launch && !one_pend_r) begin
            per_pend_r <= 1'b0;
            ptimer_r   <= per_reload;
         end else if (tick && ptimer_r != 16'h0000 && !per_pend_r) begin
            ptimer_r <= ptimer_r - 16'h0001;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_r    <= ACC_IDLE;
         chan_r     <= 4'h0;
         cur_mask_r <= 16'h0000;
         cur_per_r  <= 1'b0;
         start_r    <= 1'b0;
      end else if (hw_rst) begin
         state_r <= ACC_IDLE;
         start_r <= 1'b0;
      end else begin
         start_r <= 1'b0;
         unique case (state_r)
            ACC_IDLE: begin
               if (launch) begin
                  cur_mask_r <= one_pend_r ? smask_r : pmask_r;
                  cur_per_r  <= !one_pend_r;
                  state_r    <= ACC_SCAN;
               end
            end
            ACC_SCAN: begin
               if (first_ch[4]) begin
                  state_r <= ACC_WAIT;
                  chan_r  <= 4'hf;
               end else begin
                  chan_r  <= first_ch[3:0];
                  start_r <= 1'b1;
                  state_r <= ACC_WAIT;
               end
            end
            ACC_WAIT: begin
               if (cur_mask_r == 16'h0000 || cv.done) begin
                  if (after_ch[4] || cur_mask_r == 16'h0000) begin
                     state_r <= ACC_IDLE;
                  end else begin
                     chan_r  <= after_ch[3:0];
                     start_r <= 1'b1;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         act_q_r          <= 1'b0;
         core_reset_o     <= 1'b0;
         core_powerdown_o <= 1'b1;
         oneshot_irq_o    <= 1'b0;
         periodic_irq_o   <= 1'b0;
         mux_chan_o       <= 4'h0;
         busy_o           <= 1'b0;
         rdata_r          <= 32'h0000_0000;
      end else begin
         act_q_r          <= act;
         core_reset_o     <= hw_rst || (act && !act_q_r);
         core_powerdown_o <= idle && !launch && (!act || !ctrl_r[acc_pkg::B_PWRDN_DIS]);
         oneshot_irq_o    <= ctrl_r[acc_pkg::B_ONE_DONE];
         periodic_irq_o   <= ctrl_r[acc_pkg::B_PER_DONE];
         mux_chan_o       <= chan_r;
         busy_o           <= !idle;
         unique case (addr_i)
            acc_pkg::OFF_CTRL:  rdata_r <= {24'h000000, ctrl_r};
            acc_pkg::OFF_DELAY: rdata_r <= delay_r;
            acc_pkg::OFF_SMASK: rdata_r <= {16'h0000, smask_r};
            acc_pkg::OFF_PMASK: rdata_r <= {16'h0000, pmask_r};
            default:            rdata_r <= 32'h0000_0000;
         endcase
         if (!rd_i) begin
            rdata_r <= 32'h0000_0000;
         end
      end
   end

   assign rdata_o = rdata_r;
endmodule

// >>> logic/acc_pkg.sv
package acc_pkg;
   localparam int           NCH            = 16;
   localparam logic [7:0]   OFF_CTRL       = 8'h00;
   localparam logic [7:0]   OFF_DELAY      = 8'h04;
   localparam logic [7:0]   OFF_SMASK      = 8'h0c;
   localparam logic [7:0]   OFF_PMASK      = 8'h10;
   localparam int           B_ACTIVATE     = 0;
   localparam int           B_ONESHOT_RUN  = 1;
   localparam int           B_PERIODIC_RUN = 2;
   localparam int           B_PWRDN_DIS    = 3;
   localparam int           B_CORE_RESET   = 4;
   localparam int           B_PER_DONE     = 6;
   localparam int           B_ONE_DONE     = 7;
   localparam logic [31:0]  CTRL_RESET     = 32'h0000_0000;
   localparam int           CLK_HZ         = 125_000_000;
   localparam int           TICK_US        = 40;
   localparam int           TICK_CYC       = CLK_HZ / 1_000_000 * TICK_US;
   localparam int           CONV_CYC       = 141;
   localparam int           START_PULSE_CYC = 1;
endpackage

// >>> logic/acc_conv_if.sv
`timescale 1ns/1ps
interface acc_conv_if;
   logic       start;
   logic [3:0] chan;
   logic       done;
   logic       hold;
   modport ctl  (output start, output chan, output hold, input done);
   modport core (input start, input chan, input hold, output done);
endinterface

// >>> logic/acc_tick.sv
`timescale 1ns/1ps
module acc_tick #(
   parameter int TICK_CYC = acc_pkg::TICK_CYC
) (
   input  wire logic ref_clk_i,
   input  wire logic nrst_i,
   input  wire logic clr_i,
   output logic      tick_o
);
   logic [15:0] cnt_r;
   wire         wrap = (cnt_r == 16'(TICK_CYC - 1));

   // Free-running 40 us unit tick, restarted by clr_i.
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_r  <= 16'h0000;
         tick_o <= 1'b0;
      end else begin
         cnt_r  <= (clr_i || wrap) ? 16'h0000 : cnt_r + 16'h0001;
         tick_o <= wrap && !clr_i;
      end
   end
endmodule

// >>> logic/acc_core_timer.sv
`timescale 1ns/1ps
module acc_core_timer #(
   parameter int CONV_CYC = acc_pkg::CONV_CYC
) (
   input  wire logic ref_clk_i,
   input  wire logic nrst_i,
   acc_conv_if.core  cv
);
   logic [7:0] cnt_r;
   logic       busy_r;
   logic       done_r;

   assign cv.done = done_r;

   // Models the per-channel conversion time of the analog core.
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_r  <= 8'h00;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else if (cv.hold) begin
         cnt_r  <= 8'h00;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         done_r <= busy_r && (cnt_r == 8'(CONV_CYC - 1));
         if (cv.start) begin
            busy_r <= 1'b1;
            cnt_r  <= 8'h00;
         end else if (busy_r) begin
            if (cnt_r == 8'(CONV_CYC - 1)) begin
               busy_r <= 1'b0;
            end
            cnt_r <= cnt_r + 8'h01;
         end
      end
   end
endmodule

// >>> tb/acc_ctrl_properties.sv
`timescale 1ns/1ps
module acc_ctrl_properties #(
   parameter int TICK_CYC = 4,
   parameter int CONV_CYC = 5
) (
   input wire logic        ref_clk_i,
   input wire logic        nrst_i,
   input wire logic [7:0]  addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic [31:0] rdata_o,
   input wire logic        oneshot_irq_o,
   input wire logic        periodic_irq_o,
   input wire logic        core_reset_o,
   input wire logic        core_powerdown_o,
   input wire logic [3:0]  mux_chan_o,
   input wire logic        busy_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!nrst_i);
   wire ctl_wr = wr_i && addr_i == acc_pkg::OFF_CTRL;
   wire ctl_rd = rd_i && addr_i == acc_pkg::OFF_CTRL;
   property p_rd_idle;
      !rd_i |=> rdata_o == 32'h0;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
   property p_irq_copy;
      ctl_rd |=> rdata_o[7] == oneshot_irq_o && rdata_o[6] == periodic_irq_o;
   endproperty
   a_irq_copy: assert property (p_irq_copy) else $error("irq differs from flag");
   property p_rsvd;
      ctl_rd |=> rdata_o[31:8] == 24'h0 && !rdata_o[5];
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
   property p_hold;
      ctl_wr && wdata_i[4] |-> ##[1:2] core_reset_o;
   endproperty
   a_hold: assert property (p_hold) else $error("core not held");
   property p_release;
      ctl_wr && !wdata_i[4] && !wdata_i[0] |-> ##2 !core_reset_o;
   endproperty
   a_release: assert property (p_release) else $error("core not released");
   property p_pwr_dis;
      ctl_wr && wdata_i[3] && wdata_i[0] |-> ##2 !core_powerdown_o;
   endproperty
   a_pwr_dis: assert property (p_pwr_dis) else $error("powered down");
   property p_busy_on;
      busy_o && $past(busy_o) |-> !core_powerdown_o;
   endproperty
   a_busy_on: assert property (p_busy_on) else $error("down while busy");
   property p_done_clr;
      ctl_wr && wdata_i[7] && !wdata_i[1] && !busy_o && !$past(busy_o)
         && !$past(busy_o, 2) |-> ##2 !oneshot_irq_o;
   endproperty
   a_done_clr: assert property (p_done_clr) else $error("done not cleared");
endmodule

bind acc_ctrl acc_ctrl_properties #(.TICK_CYC(TICK_CYC), .CONV_CYC(CONV_CYC)) u_props (
   .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .oneshot_irq_o(oneshot_irq_o),
   .periodic_irq_o(periodic_irq_o), .core_reset_o(core_reset_o),
   .core_powerdown_o(core_powerdown_o), .mux_chan_o(mux_chan_o), .busy_o(busy_o));

// >>> tb/acc_mux_model.sv
`timescale 1ns/1ps
module acc_mux_model (
   input wire logic       ref_clk_i,
   input wire logic       nrst_i,
   input wire logic       busy_i,
   input wire logic [3:0] chan_i
);
   logic [63:0] trace_r;
   logic        busy_d1_r;
   logic        busy_d2_r;
   // Logs each channel the converter is pointed at, newest in the low nibble.
   // The channel output settles a cycle after busy rises, so logging waits that cycle.
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         trace_r   <= 64'h0;
         busy_d1_r <= 1'b0;
         busy_d2_r <= 1'b0;
      end else begin
         busy_d1_r <= busy_i;
         busy_d2_r <= busy_d1_r;
         if (busy_i && busy_d1_r && (!busy_d2_r || chan_i != trace_r[3:0])) begin
            trace_r <= {trace_r[59:0], chan_i};
         end
      end
   end
endmodule

// >>> tb/adc_conversion_control_tb.sv
`timescale 1ns/1ps
module adc_conversion_control_tb;
   localparam logic [7:0] CTL = acc_pkg::OFF_CTRL;
   logic        ref_clk_i;
   logic        nrst_i;
   logic [7:0]  addr_i;
   logic [31:0] wdata_i;
   logic        wr_i;
   logic        rd_i;
   logic [31:0] rdata_o;
   logic        oneshot_irq_o;
   logic        periodic_irq_o;
   logic        core_reset_o;
   logic        core_powerdown_o;
   logic [3:0]  mux_chan_o;
   logic        busy_o;
   logic [31:0] d;
   int          k;
   int          n_errors;
   int          comparisons;
   acc_ctrl #(.TICK_CYC(4), .CONV_CYC(5)) DUT (
      .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .oneshot_irq_o(oneshot_irq_o),
      .periodic_irq_o(periodic_irq_o), .core_reset_o(core_reset_o),
      .core_powerdown_o(core_powerdown_o), .mux_chan_o(mux_chan_o), .busy_o(busy_o));
   acc_mux_model u_mux (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .busy_i(busy_o),
      .chan_i(mux_chan_o));
   initial begin
      ref_clk_i = 1'b0;
      forever #4 ref_clk_i = ~ref_clk_i;
   end
   task automatic final_report;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %0t got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk_i);
      addr_i  <= a;
      wdata_i <= v;
      wr_i    <= 1'b1;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      @(negedge ref_clk_i);
      d = rdata_o;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask
   task automatic wait_busy(input logic lvl);
      k = 0;
      while (busy_o !== lvl && k < 400) begin
         @(negedge ref_clk_i);
         k++;
      end
      if (k == 400) begin
         n_errors++;
         $display("BAD %0t busy wait", $time);
      end
   endtask
   task automatic gap;
      k = 0;
      while (busy_o === 1'b1 && k < 400) begin
         @(negedge ref_clk_i);
         k++;
      end
      while (busy_o !== 1'b1 && k < 400) begin
         @(negedge ref_clk_i);
         k++;
      end
   endtask
   task automatic pulses(input logic [31:0] v, input int n);
      wr(CTL, v);
      k = 0;
      repeat (6) begin
         @(negedge ref_clk_i);
         k += int'(core_reset_o);
      end
      check(32'(k), 32'(n));
   endtask
   task automatic t_reset;
      check(32'({oneshot_irq_o, periodic_irq_o, core_reset_o, core_powerdown_o}), 32'h1);
      rd(CTL);
      check(d, acc_pkg::CTRL_RESET);
      wr(CTL, 32'hffff_ff20);
      rd(CTL);
      check(d, 32'h0);
      wr(8'h40, 32'hffff_ffff);
      rd(8'h40);
      check(d, 32'h0);
   endtask
   task automatic t_hold_power;
      wr(CTL, 32'h10);
      rd(CTL);
      check(d, 32'h10);
      check(32'(core_reset_o), 32'h1);
      wr(CTL, 32'h0);
      cyc(2);
      check(32'(core_reset_o), 32'h0);
      pulses(32'h1, 1);
      pulses(32'h1, 0);
      check(32'(core_powerdown_o), 32'h1);
      wr(CTL, 32'h9);
      cyc(2);
      check(32'(core_powerdown_o), 32'h0);
      wr(CTL, 32'h1);
      cyc(2);
      check(32'(core_powerdown_o), 32'h1);
   endtask
   task automatic t_oneshot;
      wr(acc_pkg::OFF_SMASK, 32'h5);
      repeat (2) begin
         wr(CTL, 32'h3);
         wait_busy(1'b1);
         rd(CTL);
         check(d, 32'h1);
         wait_busy(1'b0);
         cyc(3);
         check(32'(oneshot_irq_o), 32'h1);
         check(32'(u_mux.trace_r[7:0]), 32'h02);
      end
      wr(CTL, 32'h1);
      rd(CTL);
      check(d, 32'h81);
      wr(CTL, 32'h81);
      rd(CTL);
      check(d, 32'h1);
   endtask
   task automatic t_periodic;
      wr(acc_pkg::OFF_PMASK, 32'h8002);
      wr(acc_pkg::OFF_DELAY, 32'h000a_0002);
      wr(CTL, 32'h5);
      gap;
      check(32'(k >= 6 && k <= 14), 32'h1);
      gap;
      check(32'(k >= 36 && k <= 46), 32'h1);
      rd(CTL);
      check(d, 32'h5);
      wr(CTL, 32'h1);
      cyc(1);
      check(32'(busy_o), 32'h1);
      wait_busy(1'b0);
      cyc(3);
      check(32'(periodic_irq_o), 32'h1);
      check(32'(u_mux.trace_r[7:0]), 32'h1f);
      gap;
      check(32'(k), 32'd400);
   endtask
   task automatic t_priority;
      wr(acc_pkg::OFF_SMASK, 32'h1);
      wr(acc_pkg::OFF_PMASK, 32'h8000);
      wr(acc_pkg::OFF_DELAY, 32'h00ff_0000);
      wr(CTL, 32'h47);
      wait_busy(1'b1);
      cyc(30);
      check(32'(u_mux.trace_r[7:0]), 32'h0f);
      check(32'({oneshot_irq_o, periodic_irq_o}), 32'h3);
      wr(CTL, 32'hc1);
      cyc(3);
      check(32'({oneshot_irq_o, periodic_irq_o}), 32'h0);
   endtask
   task automatic t_deactivate;
      wr(acc_pkg::OFF_SMASK, 32'hffff);
      wr(CTL, 32'h3);
      wait_busy(1'b1);
      wr(CTL, 32'h0);
      cyc(1);
      check(32'(busy_o), 32'h1);
      wait_busy(1'b0);
      cyc(3);
      rd(CTL);
      check(d, 32'h80);
      check(32'(core_powerdown_o), 32'h1);
      wr(CTL, 32'h2);
      gap;
      check(32'(k), 32'd400);
   endtask
   initial begin
      #400000;
      n_errors++;
      $display("BAD %0t watchdog", $time);
      final_report;
   end
   initial begin
      nrst_i      = 1'b0;
      addr_i      = 8'h00;
      wdata_i     = 32'h0;
      wr_i        = 1'b0;
      rd_i        = 1'b0;
      n_errors    = 0;
      comparisons = 0;
      repeat (4) @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      @(negedge ref_clk_i);
      t_reset;
      t_hold_power;
      t_oneshot;
      t_periodic;
      t_priority;
      t_deactivate;
      final_report;
   end
endmodule
